// ### verilog/gp_timer.sv
// Two-half timer: triggers, chaining, enables, interrupt flags, load values
// Functional notes
// (R1) Trigger output pulses on timeout only while its enable is set.
// (R2) Trigger, wait, enable, disable, load act on A, B or both.
// (R3) With wait set, a half starts only after the chain trigger.
// (R4) Disable stops the selected half.
// (R5) Software configures mode before enabling.
// (R6) Seven sticky flags: capture event, match, timeout per half, RTC.
// (R7) Only enabled flags drive the interrupt output.
// (R8) Status reads raw or masked flags, same layout.
// (R9) Clear mask drops exactly the named flags; flags stick until cleared.
// (R10) Handler clears flags early, not as its last action.
// (R11) Programmed load value of a half or joined timer reads back.
// (R12) A load write goes into the counter at once.
// (R13) In joined mode software addresses half A only.
// (R14) Single-word load serves half modes; joined mode uses 64-bit access.
// (R15) Joined mode reads back the whole 64-bit load value.
// (R16) Two 32-bit halves, separate or joined into one 64-bit counter.
// (R17) With stall handling set, a half freezes while in debug mode.
// (R18) Without wait, an enabled half counts from the next clock.
module gp_timer (
    input  wire logic                             core_clk,
    input  wire logic                             rst,
    input  wire logic                             fullWidth,
    input  wire logic                             selA,
    input  wire logic                             selB,
    input  wire logic                             trigEnWr,
    input  wire logic                             trigEnVal,
    input  wire logic                             waitWr,
    input  wire logic                             waitVal,
    input  wire logic                             stallWr,
    input  wire logic                             stallVal,
    input  wire logic                             enableWr,
    input  wire logic                             disableWr,
    input  wire logic                             loadWr,
    input  wire logic [gp_timer_pkg::HALF_W-1:0]  loadVal,
    input  wire logic                             load64Wr,
    input  wire logic [gp_timer_pkg::FULL_W-1:0]  load64Val,
    input  wire logic                             intEnWr,
    input  wire logic                             intDisWr,
    input  wire logic                             intClrWr,
    input  wire logic [gp_timer_pkg::FLAG_W-1:0]  intFlags,
    input  wire logic                             maskedStatusSelect,
    input  wire logic                             readSelB,
    input  wire logic                             debugMode,
    input  wire logic                             chainTrigIn,
    input  wire logic                             capEventA,
    input  wire logic                             capMatchA,
    input  wire logic                             capEventB,
    input  wire logic                             capMatchB,
    input  wire logic                             rtcMatch,
    output logic                                  trigOutA,
    output logic                                  trigOutB,
    output logic                                  irq,
    output logic      [gp_timer_pkg::FLAG_W-1:0]  intStatus,
    output logic      [gp_timer_pkg::FULL_W-1:0]  loadReadback,
    output logic                                  runningA,
    output logic                                  runningB
);
    gp_timer_pkg::timer_state_t st_r;
    gp_timer_pkg::timer_state_t st_nxt;

    logic [gp_timer_pkg::HALF_W-1:0] cntA;
    logic [gp_timer_pkg::HALF_W-1:0] cntB;
    logic                            zeroA;
    logic                            zeroB;
    logic                            goA;
    logic                            goB;
    logic                            runHA;
    logic                            runHB;
    logic                            timeoutA;
    logic                            timeoutB;
    logic                            ldA;
    logic                            ldB;
    logic [gp_timer_pkg::HALF_W-1:0] ldValA;
    logic [gp_timer_pkg::HALF_W-1:0] ldValB;
    logic [gp_timer_pkg::FLAG_W-1:0] setVec;
    logic                            wrA;
    logic                            wrB;

    // Next arming state of one half from enable, disable and chain trigger
    function automatic gp_timer_pkg::half_state_t next_st(
        input gp_timer_pkg::half_state_t cur,
        input logic                      en,
        input logic                      dis,
        input logic                      wt,
        input logic                      trig
    );
        gp_timer_pkg::half_state_t n;
        n = cur;
        if (dis) begin
            n = gp_timer_pkg::ST_OFF;                          // R4
        end else if (cur == gp_timer_pkg::ST_OFF && en) begin
            n = wt ? gp_timer_pkg::ST_WAIT : gp_timer_pkg::ST_RUN; // R18
        end else if (cur == gp_timer_pkg::ST_WAIT && trig) begin
            n = gp_timer_pkg::ST_RUN;                          // R3
        end
        return n;
    endfunction : next_st

    // Joined mode uses half A controls for the whole counter
    assign wrA = selA;
    assign wrB = selB && !fullWidth;                            // R13

    always_comb begin
        goA = (st_r.stA == gp_timer_pkg::ST_RUN)
              && !(st_r.stallA && st_r.dbg2);                   // R17
        goB = (st_r.stB == gp_timer_pkg::ST_RUN)
              && !(st_r.stallB && st_r.dbg2);                   // R17
        if (fullWidth) begin                                    // R16
            runHA    = goA;
            runHB    = goA && zeroA && !zeroB;
            timeoutA = goA && zeroA && zeroB;
            timeoutB = 1'b0;
        end else begin
            runHA    = goA;
            runHB    = goB;
            timeoutA = goA && zeroA;
            timeoutB = goB && zeroB;
        end
        ldA = (loadWr && wrA) || load64Wr || timeoutA;          // R12
        ldB = (loadWr && wrB) || load64Wr || timeoutB
              || (fullWidth && timeoutA);                       // R12
        if (load64Wr) begin                                     // R14
            ldValA = load64Val[gp_timer_pkg::HALF_W-1:0];
            ldValB = load64Val[gp_timer_pkg::FULL_W-1:gp_timer_pkg::HALF_W];
        end else begin
            ldValA = (loadWr && wrA) ? loadVal : st_r.loadA;
            ldValB = (loadWr && wrB) ? loadVal : st_r.loadB;
        end
        setVec = '0;                                            // R6
        setVec[gp_timer_pkg::FLAG_A_TIMEOUT]   = timeoutA;
        setVec[gp_timer_pkg::FLAG_A_CAP_MATCH] = capMatchA;
        setVec[gp_timer_pkg::FLAG_A_CAP_EVENT] = capEventA;
        setVec[gp_timer_pkg::FLAG_RTC_MATCH]   = rtcMatch;
        setVec[gp_timer_pkg::FLAG_B_TIMEOUT]   = timeoutB;
        setVec[gp_timer_pkg::FLAG_B_CAP_MATCH] = capMatchB;
        setVec[gp_timer_pkg::FLAG_B_CAP_EVENT] = capEventB;
    end

    always_comb begin
        st_nxt      = st_r;
        st_nxt.dbg1 = debugMode;
        st_nxt.dbg2 = st_r.dbg1;
        if (trigEnWr && wrA) st_nxt.trigEnA = trigEnVal;        // R2
        if (trigEnWr && wrB) st_nxt.trigEnB = trigEnVal;        // R2
        if (waitWr && wrA) st_nxt.waitA = waitVal;              // R2
        if (waitWr && wrB) st_nxt.waitB = waitVal;              // R2
        if (stallWr && wrA) st_nxt.stallA = stallVal;
        if (stallWr && wrB) st_nxt.stallB = stallVal;
        st_nxt.stA = next_st(st_r.stA, enableWr && wrA,
                             disableWr && wrA, st_r.waitA, chainTrigIn);
        st_nxt.stB = next_st(st_r.stB, enableWr && wrB,
                             disableWr && wrB, st_r.waitB, chainTrigIn);
        if (load64Wr) begin                                     // R14
            st_nxt.loadA = ldValA;
            st_nxt.loadB = ldValB;
        end else if (loadWr) begin                              // R2
            if (wrA) st_nxt.loadA = loadVal;
            if (wrB) st_nxt.loadB = loadVal;
        end
        if (intEnWr) st_nxt.mask = st_r.mask | intFlags;        // R7
        if (intDisWr) st_nxt.mask = st_nxt.mask & ~intFlags;    // R7
        // Set wins over a clear in the same cycle
        st_nxt.raw = (st_r.raw & ~(intClrWr ? intFlags : '0))
                     | setVec;                                  // R9
        st_nxt.irq = |(st_nxt.raw & st_nxt.mask);               // R7
        st_nxt.status = maskedStatusSelect
                        ? (st_nxt.raw & st_nxt.mask) : st_nxt.raw; // R8
        if (fullWidth) begin
            st_nxt.loadRd = {st_nxt.loadB, st_nxt.loadA};       // R15
        end else begin
            st_nxt.loadRd = {32'h0000_0000,
                readSelB ? st_nxt.loadB : st_nxt.loadA};        // R11
        end
        st_nxt.trigOutA = timeoutA && st_r.trigEnA;             // R1
        st_nxt.trigOutB = timeoutB && st_r.trigEnB;             // R1
        st_nxt.runA = runHA;
        st_nxt.runB = runHB && !fullWidth;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r.stA      <= gp_timer_pkg::ST_OFF;
            st_r.stB      <= gp_timer_pkg::ST_OFF;
            st_r.trigEnA  <= 1'b0;
            st_r.trigEnB  <= 1'b0;
            st_r.waitA    <= 1'b0;
            st_r.waitB    <= 1'b0;
            st_r.stallA   <= 1'b0;
            st_r.stallB   <= 1'b0;
            st_r.loadA    <= gp_timer_pkg::LOAD_RST;
            st_r.loadB    <= gp_timer_pkg::LOAD_RST;
            st_r.raw      <= gp_timer_pkg::FLAGS_RST;
            st_r.mask     <= gp_timer_pkg::FLAGS_RST;
            st_r.dbg1     <= 1'b0;
            st_r.dbg2     <= 1'b0;
            st_r.trigOutA <= 1'b0;
            st_r.trigOutB <= 1'b0;
            st_r.irq      <= 1'b0;
            st_r.status   <= gp_timer_pkg::FLAGS_RST;
            st_r.loadRd   <= 64'h0000_0000_0000_0000;
            st_r.runA     <= 1'b0;
            st_r.runB     <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    half_counter u_half_a (
        .core_clk (core_clk),
        .rst      (rst),
        .run      (runHA),
        .load     (ldA),
        .loadVal  (ldValA),
        .count    (cntA),
        .zero     (zeroA)
    );

    half_counter u_half_b (
        .core_clk (core_clk),
        .rst      (rst),
        .run      (runHB),
        .load     (ldB),
        .loadVal  (ldValB),
        .count    (cntB),
        .zero     (zeroB)
    );

    assign trigOutA     = st_r.trigOutA;
    assign trigOutB     = st_r.trigOutB;
    assign irq          = st_r.irq;
    assign intStatus    = st_r.status;
    assign loadReadback = st_r.loadRd;
    assign runningA     = st_r.runA;
    assign runningB     = st_r.runB;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_enable_a_nowait;
        st_r.stA == gp_timer_pkg::ST_OFF && enableWr && selA
        && !disableWr && !st_r.waitA;
    endsequence
    // Running in the cycle after enable, so the count moves at the next edge
    sequence s_a_counts;
        st_r.stA == gp_timer_pkg::ST_RUN
        ##1 (cntA != $past(cntA) || $past(ldA));
    endsequence

    property p_trig_gated;
        trigOutA |-> $past(timeoutA && st_r.trigEnA);
    endproperty
    a_trig_gated: assert property (p_trig_gated) // R1
        else $error("trigger A pulsed without timeout or enable");

    property p_enable_both;
        enableWr && selA && selB && !disableWr && !fullWidth
        |=> st_r.stA != gp_timer_pkg::ST_OFF
            && st_r.stB != gp_timer_pkg::ST_OFF;
    endproperty
    a_enable_both: assert property (p_enable_both) // R2
        else $error("enable of both halves did not take");

    property p_wait_hold;
        st_r.stB == gp_timer_pkg::ST_WAIT && !chainTrigIn && !disableWr
        |=> st_r.stB == gp_timer_pkg::ST_WAIT;
    endproperty
    a_wait_hold: assert property (p_wait_hold) // R3
        else $error("half B left wait without chain trigger");

    property p_disable;
        disableWr && selA |=> st_r.stA == gp_timer_pkg::ST_OFF ##1 !runningA;
    endproperty
    a_disable: assert property (p_disable) // R4
        else $error("half A kept running after disable");

    property p_irq;
        irq == |(st_r.raw & st_r.mask);
    endproperty
    a_irq: assert property (p_irq) // R7
        else $error("interrupt output disagrees with masked flags");

    property p_masked_status;
        maskedStatusSelect |=> intStatus == (st_r.raw & st_r.mask);
    endproperty
    a_masked_status: assert property (p_masked_status) // R8
        else $error("masked status wrong");

    property p_clear;
        intClrWr |=> (st_r.raw & $past(intFlags & ~setVec)) == '0;
    endproperty
    a_clear: assert property (p_clear) // R9
        else $error("cleared flag still set");

    property p_load_now;
        loadWr && selA && !load64Wr |=> cntA == $past(loadVal);
    endproperty
    a_load_now: assert property (p_load_now) // R12
        else $error("load value not taken into counter at once");

    property p_load64_rd;
        load64Wr && fullWidth ##1 fullWidth && !loadWr && !load64Wr
        |=> loadReadback == $past(load64Val, 2);
    endproperty
    a_load64_rd: assert property (p_load64_rd) // R15
        else $error("64-bit load readback wrong");

    property p_stall;
        st_r.stallA && st_r.dbg2 && !ldA |=> cntA == $past(cntA);
    endproperty
    a_stall: assert property (p_stall) // R17
        else $error("half A counted during debug stall");

    property p_start;
        s_enable_a_nowait ##1 !disableWr && !(st_r.stallA && st_r.dbg2)
        |-> s_a_counts;
    endproperty
    a_start: assert property (p_start) // R18
        else $error("half A did not count on the clock after enable");
endmodule : gp_timer

// ### verilog/gp_timer_pkg.sv
// Shared constants and types for the general-purpose timer
package gp_timer_pkg;
    localparam int HALF_W = 32;
    localparam int FULL_W = 64;
    localparam int NFLAGS = 7;

    // Interrupt flag bit positions, same layout for raw and masked status
    localparam int FLAG_A_TIMEOUT   = 0;
    localparam int FLAG_A_CAP_MATCH = 1;
    localparam int FLAG_A_CAP_EVENT = 2;
    localparam int FLAG_RTC_MATCH   = 3;
    localparam int FLAG_B_TIMEOUT   = 8;
    localparam int FLAG_B_CAP_MATCH = 9;
    localparam int FLAG_B_CAP_EVENT = 10;
    localparam int FLAG_W           = 11;

    localparam logic [HALF_W-1:0] LOAD_RST  = 32'h0000_0000;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 11'h000;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } half_state_t;

    typedef struct packed {
        half_state_t        stA;
        half_state_t        stB;
        logic               trigEnA;
        logic               trigEnB;
        logic               waitA;
        logic               waitB;
        logic               stallA;
        logic               stallB;
        logic [HALF_W-1:0]  loadA;
        logic [HALF_W-1:0]  loadB;
        logic [FLAG_W-1:0]  raw;
        logic [FLAG_W-1:0]  mask;
        logic               dbg1;
        logic               dbg2;
        logic               trigOutA;
        logic               trigOutB;
        logic               irq;
        logic [FLAG_W-1:0]  status;
        logic [FULL_W-1:0]  loadRd;
        logic               runA;
        logic               runB;
    } timer_state_t;

    typedef struct packed {
        logic [HALF_W-1:0] count;
    } half_cnt_t;
endpackage : gp_timer_pkg

// ### verilog/half_counter.sv
// One 32-bit down-counting half with immediate load
module half_counter (
    input  wire logic                           core_clk,
    input  wire logic                           rst,
    input  wire logic                           run,
    input  wire logic                           load,
    input  wire logic [gp_timer_pkg::HALF_W-1:0] loadVal,
    output logic      [gp_timer_pkg::HALF_W-1:0] count,
    output logic                                zero
);
    gp_timer_pkg::half_cnt_t s_r;
    gp_timer_pkg::half_cnt_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (load) begin
            s_nxt.count = loadVal;
        end else if (run) begin
            s_nxt.count = s_r.count - 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_r.count <= gp_timer_pkg::LOAD_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign count = s_r.count;
    assign zero  = (s_r.count == 32'h0000_0000);
endmodule : half_counter

// ### verification/chain_neighbour.sv
// Neighbour timer model that feeds the chain trigger input
module chain_neighbour (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic [7:0] period,
    output logic            chainTrig
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_r;

    // Counts its own period while running, one-cycle pulse per timeout
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r     <= 8'h00;
            chainTrig <= 1'b0;
        end else if (!go) begin
            cnt_r     <= period;
            chainTrig <= 1'b0;
        end else if (cnt_r == 8'h00) begin
            cnt_r     <= period;
            chainTrig <= 1'b1;
        end else begin
            cnt_r     <= cnt_r - 8'h01;
            chainTrig <= 1'b0;
        end
    end
endmodule : chain_neighbour

// ### verification/gp_timer_bench.sv
// Self-checking bench for the two-half timer
module gp_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

    localparam int TRG = 0, WTG = 1, STL = 2, ENA = 3, DIS = 4;
    localparam int LD = 5, LD64 = 6, IEN = 7, IDIS = 8, ICLR = 9;

    logic        core_clk, rst, fullWidth, selA, selB, trigEnVal, waitVal;
    logic        stallVal, maskedStatusSelect, readSelB, debugMode, go;
    logic        trigEnWr, waitWr, stallWr, enableWr, disableWr, loadWr;
    logic        load64Wr, intEnWr, intDisWr, intClrWr, seen;
    logic        capEventA, capMatchA, capEventB, capMatchB, rtcMatch;
    logic        chainTrigIn, trigOutA, trigOutB, irq, runningA, runningB;
    logic [31:0] loadVal;
    logic [63:0] load64Val, loadReadback;
    logic [10:0] intFlags, intStatus;
    int          n_errors, num_checks, chainCnt, n;

    gp_timer DUT (.*);

    chain_neighbour NEIGH (
        .core_clk  (core_clk),
        .rst       (rst),
        .go        (go),
        .period    (8'h05),
        .chainTrig (chainTrigIn)
    );

    always #20 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (chainTrigIn === 1'b1) chainCnt++;
    end

    task summarize();
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // Drives only the strobe picked by k, so no other strobe is touched
    task strobe(input int k, input logic v);
        case (k)
            TRG:  trigEnWr = v;
            WTG:  waitWr = v;
            STL:  stallWr = v;
            ENA:  enableWr = v;
            DIS:  disableWr = v;
            LD:   loadWr = v;
            LD64: load64Wr = v;
            IEN:  intEnWr = v;
            IDIS: intDisWr = v;
            default: intClrWr = v;
        endcase
    endtask : strobe

    // One strobe for one cycle; d carries value, flags and the enable bit
    task op(input int k, input logic a, input logic b, input logic [63:0] d);
        selA = a;
        selB = b;
        loadVal = d[31:0];
        load64Val = d;
        intFlags = d[10:0];
        {trigEnVal, waitVal, stallVal} = {3{d[0]}};
        strobe(k, 1'b1);
        @(negedge core_clk);
        strobe(k, 1'b0);
    endtask : op

    // Cycles until trigOutA (which 0) or runningB (which 1) is seen high
    task waitSig(input int which, input int lim);
        n = 0;
        while (n < lim) begin
            @(negedge core_clk);
            n++;
            if ((which == 0 && trigOutA === 1'b1) ||
                (which == 1 && runningB === 1'b1)) return;
        end
        n_errors++;
        summarize();
    endtask : waitSig

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        {fullWidth, selA, selB, trigEnVal, waitVal, stallVal} = '0;
        {maskedStatusSelect, readSelB, debugMode, go} = '0;
        {trigEnWr, waitWr, stallWr, enableWr, disableWr, loadWr} = '0;
        {load64Wr, intEnWr, intDisWr, intClrWr} = '0;
        {capEventA, capMatchA, capEventB, capMatchB, rtcMatch} = '0;
        {loadVal, load64Val, intFlags} = '0;
        {n_errors, num_checks, chainCnt} = '0;
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        `CHK("idle", '0, {trigOutA, trigOutB, irq, runningA, runningB,
                          intStatus, loadReadback})

        op(LD, 1, 1, 64'h9);
        `CHK("load A", 32'h9, loadReadback[31:0])
        readSelB = 1'b1;
        @(negedge core_clk);
        `CHK("load B", 32'h9, loadReadback[31:0])
        readSelB = 1'b0;

        op(TRG, 1, 0, 64'h1);
        op(IEN, 1, 0, 64'h1);
        op(LD, 1, 0, 64'hC8);
        op(ENA, 1, 0, 64'h0);
        `CHK("run A early", 1'b0, runningA)
        @(negedge core_clk);
        `CHK("run A", 1'b1, runningA)
        repeat (3) @(negedge core_clk);
        op(LD, 1, 0, 64'h4);
        waitSig(0, 300);
        `CHK("reload delay", 5, n)
        `CHK("irq", 1'b1, irq)
        waitSig(0, 300);
        `CHK("period", 5, n)
        `CHK("trig B idle", 1'b0, trigOutB)

        op(TRG, 1, 0, 64'h0);
        op(ICLR, 1, 0, 64'h1);
        seen = 1'b0;
        repeat (6) begin
            @(negedge core_clk);
            seen = seen | trigOutA;
        end
        `CHK("trig off", 1'b0, seen)
        `CHK("A timeout flag", 1'b1, intStatus[0])

        op(STL, 1, 0, 64'h1);
        debugMode = 1'b1;
        repeat (5) @(negedge core_clk);
        `CHK("stall A", 1'b0, runningA)
        debugMode = 1'b0;
        repeat (5) @(negedge core_clk);
        `CHK("resume A", 1'b1, runningA)
        op(STL, 1, 0, 64'h0);
        debugMode = 1'b1;
        repeat (5) @(negedge core_clk);
        `CHK("no stall A", 1'b1, runningA)
        debugMode = 1'b0;

        op(DIS, 1, 0, 64'h0);
        op(ICLR, 1, 1, 64'h7FF);
        repeat (8) @(negedge core_clk);
        `CHK("disabled A", 1'b0, runningA)
        `CHK("no timeout", 11'h000, intStatus)

        op(WTG, 0, 1, 64'h1);
        op(ENA, 1, 1, 64'h0);
        repeat (10) @(negedge core_clk);
        `CHK("wait B", 1'b0, runningB)
        `CHK("both A", 1'b1, runningA)
        go = 1'b1;
        waitSig(1, 40);
        `CHK("chain pulses", 1, chainCnt)
        go = 1'b0;

        op(DIS, 1, 1, 64'h0);
        op(ICLR, 1, 1, 64'h7FF);
        {capEventA, capMatchA, capEventB, capMatchB, rtcMatch} = '1;
        @(negedge core_clk);
        {capEventA, capMatchA, capEventB, capMatchB, rtcMatch} = '0;
        `CHK("raw flags", 11'h60E, intStatus)
        op(ICLR, 1, 1, 64'h00A);
        `CHK("partial clear", 11'h604, intStatus)
        op(IDIS, 1, 1, 64'h001);
        op(IEN, 1, 1, 64'h00C);
        `CHK("irq on", 1'b1, irq)
        maskedStatusSelect = 1'b1;
        @(negedge core_clk);
        `CHK("masked", 11'h004, intStatus)
        op(IDIS, 1, 1, 64'h004);
        `CHK("irq off", 1'b0, irq)
        `CHK("masked none", 11'h000, intStatus)
        maskedStatusSelect = 1'b0;
        @(negedge core_clk);
        `CHK("raw kept", 11'h604, intStatus)

        fullWidth = 1'b1;
        op(LD64, 1, 0, 64'h0123456789ABCDEF);
        `CHK("load 64", 64'h0123456789ABCDEF, loadReadback)
        @(negedge core_clk);
        op(LD, 1, 0, 64'h11111111);
        `CHK("low word", 64'h0123456711111111, loadReadback)
        fullWidth = 1'b0;
        readSelB = 1'b1;
        @(negedge core_clk);
        `CHK("split B", 32'h01234567, loadReadback[31:0])
        summarize();
    end
endmodule : gp_timer_bench
